// file: rtc_alarm_and_watchdog.sv
// alarm and watchdog unit behind the byte-wide memory bus
`timescale 1ns/10ps
`include "rtc_alarm_cfg.svh"
module rtc_alarm_and_watchdog
  import rtc_alarm_pkg::*;
#(
  parameter int unsigned RST_PULSE_CYCLES = `RST_PULSE_CYCLES
) (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic [18:0] addr,
  input wire logic [7:0] dq_in,
  output logic [7:0] dq_out,
  output logic dq_oe_n,
  input wire logic ce_n,
  input wire logic oe_n,
  input wire logic we_n,
  input wire logic osc_tick,
  input wire logic second_tick,
  input wire logic [6:0] now_sec,
  input wire logic [6:0] now_min,
  input wire logic [5:0] now_hour,
  input wire logic [5:0] now_day,
  input wire logic on_battery,
  input wire logic power_up,
  input wire logic battery_low_flag,
  input wire logic freq_test_bit,
  output logic freq_test_clear,
  output logic irq_freqtest_out,
  output logic irq_freqtest_oe_n,
  output logic rst_out,
  output logic rst_oe_n
);
  logic rst_s1_ff, rst_n_ff;
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      rst_s1_ff <= 1'b0;
      rst_n_ff <= 1'b0;
    end else begin
      rst_s1_ff <= 1'b1;
      rst_n_ff <= rst_s1_ff;
    end
  end

  // bus access tracking; effects fire at cycle end (strobe release), except the alarm interrupt clear and the interrupt pin release at flags access start
  logic acc_now, acc_ff, wr_ff;
  logic [18:0] acc_addr_ff;
  logic [7:0] wdata_ff;
  logic acc_end, wr_end;
  assign acc_now = !ce_n && (!oe_n || !we_n);
  assign acc_end = acc_ff && !acc_now;
  assign wr_end = acc_end && wr_ff;
  always_ff @(posedge clk_sys or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      acc_ff <= 1'b0;
      wr_ff <= 1'b0;
      acc_addr_ff <= 19'h00000;
      wdata_ff <= 8'h00;
    end else begin
      acc_ff <= acc_now;
      if (acc_now) begin
        acc_addr_ff <= addr;
        wr_ff <= !we_n;
        if (!we_n) wdata_ff <= dq_in;
      end
    end
  end
  logic flags_acc_now, flags_end, wd_end;
  assign flags_acc_now = acc_now && addr == `ADDR_EVENT_FLAGS;
  assign flags_end = acc_end && acc_addr_ff == `ADDR_EVENT_FLAGS;
  assign wd_end = acc_end && acc_addr_ff == `ADDR_WATCHDOG_CFG;

  // alarm registers
  logic [7:0] alarm_sec_ff, alarm_min_ff, alarm_hour_ff, alarm_day_match_ff, alarm_interrupt_enables_ff;
  always_ff @(posedge clk_sys or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      alarm_sec_ff <= `ALARM_RESET_VALUE;
      alarm_min_ff <= `ALARM_RESET_VALUE;
      alarm_hour_ff <= `ALARM_RESET_VALUE;
      alarm_day_match_ff <= `ALARM_RESET_VALUE;
      alarm_interrupt_enables_ff <= `ENABLES_RESET_VALUE;
    end else begin
      if (wr_end) begin
        case (acc_addr_ff)
          `ADDR_ALARM_SEC: alarm_sec_ff <= wdata_ff;
          `ADDR_ALARM_MIN: alarm_min_ff <= wdata_ff;
          `ADDR_ALARM_HOUR: alarm_hour_ff <= wdata_ff;
          `ADDR_ALARM_DAY_MATCH: alarm_day_match_ff <= wdata_ff;
          `ADDR_ALARM_IRQ_ENABLES: alarm_interrupt_enables_ff <= wdata_ff;
          default: ;
        endcase
      end
      if (power_up) begin
        alarm_interrupt_enables_ff[`EN_ALARM_IRQ_BIT] <= 1'b0;
        alarm_interrupt_enables_ff[`EN_BACKUP_BIT] <= 1'b0;
      end
    end
  end
  logic alarm_irq_enable, backup_enable;
  assign alarm_irq_enable = alarm_interrupt_enables_ff[`EN_ALARM_IRQ_BIT];
  assign backup_enable = alarm_interrupt_enables_ff[`EN_BACKUP_BIT];

  logic hit;
  alarm_match alarm_match_i (
    .alarm_sec(alarm_sec_ff),
    .alarm_min(alarm_min_ff),
    .alarm_hour(alarm_hour_ff),
    .alarm_day(alarm_day_match_ff),
    .now_sec(now_sec),
    .now_min(now_min),
    .now_hour(now_hour),
    .now_day(now_day),
    .hit(hit)
  );
  logic alarm_event;
  assign alarm_event = second_tick && hit;

  // alarm flag and alarm interrupt latch; set wins over clear
  logic alarm_match_flag_ff, alarm_irq_ff;
  always_ff @(posedge clk_sys or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      alarm_match_flag_ff <= 1'b0;
      alarm_irq_ff <= 1'b0;
    end else begin
      if (alarm_event) alarm_match_flag_ff <= 1'b1;
      else if (flags_end) alarm_match_flag_ff <= 1'b0;
      // pin drops as soon as flags access starts, before the flag clears
      if (alarm_event && alarm_irq_enable && (!on_battery || backup_enable)) alarm_irq_ff <= 1'b1;
      else if (flags_acc_now) alarm_irq_ff <= 1'b0;
    end
  end

  // watchdog
  logic [7:0] watchdog_timeout_config_ff;
  wd_state_t wd_state_ff;
  logic [11:0] sub_ff;
  logic [7:0] units_ff;
  logic [6:0] mult_ff;
  logic watchdog_expired_flag_ff, wd_irq_ff;
  logic [$clog2(RST_PULSE_CYCLES+1)-1:0] pulse_ff;
  logic [4:0] multiplier;
  logic [1:0] resolution;
  logic [7:0] units_per_step;
  logic wd_timeout;
  assign multiplier = watchdog_timeout_config_ff[6:2];
  assign resolution = watchdog_timeout_config_ff[1:0];
  always_comb begin
    case (resolution)
      2'b00: units_per_step = 8'h01;
      2'b01: units_per_step = 8'h04;
      2'b10: units_per_step = 8'h10;
      default: units_per_step = 8'h40;
    endcase
  end
  assign wd_timeout = wd_state_ff == WD_COUNT && osc_tick && sub_ff == `TICKS_SIXTEENTH - 12'd1
    && units_ff == units_per_step - 8'h01 && mult_ff == {2'b00, multiplier} - 7'd1;

  always_ff @(posedge clk_sys or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      watchdog_timeout_config_ff <= `WDOG_RESET_VALUE;
      wd_state_ff <= WD_IDLE;
      sub_ff <= 12'h000;
      units_ff <= 8'h00;
      mult_ff <= 7'h00;
      pulse_ff <= '0;
    end else if (power_up) begin
      watchdog_timeout_config_ff <= `WDOG_RESET_VALUE;
      wd_state_ff <= WD_IDLE;
    end else begin
      if (wr_end && acc_addr_ff == `ADDR_WATCHDOG_CFG) watchdog_timeout_config_ff <= wdata_ff;
      case (wd_state_ff)
        WD_IDLE: begin
          if (wd_end && !(wr_end && wdata_ff == 8'h00)) wd_state_ff <= WD_COUNT;
          sub_ff <= 12'h000;
          units_ff <= 8'h00;
          mult_ff <= 7'h00;
        end
        WD_COUNT: begin
          if (wd_end) begin
            sub_ff <= 12'h000;
            units_ff <= 8'h00;
            mult_ff <= 7'h00;
            if (wr_end && wdata_ff == 8'h00) wd_state_ff <= WD_IDLE;
          end else if (multiplier == 5'h00) begin
            wd_state_ff <= WD_IDLE;
          end else if (wd_timeout) begin
            sub_ff <= 12'h000;
            units_ff <= 8'h00;
            mult_ff <= 7'h00;
            if (watchdog_timeout_config_ff[`WDOG_STEER_BIT]) begin
              wd_state_ff <= WD_RSTPULSE;
              pulse_ff <= '0;
            end
          end else if (osc_tick) begin
            if (sub_ff == `TICKS_SIXTEENTH - 12'd1) begin
              sub_ff <= 12'h000;
              if (units_ff == units_per_step - 8'h01) begin
                units_ff <= 8'h00;
                mult_ff <= mult_ff + 7'd1;
              end else begin
                units_ff <= units_ff + 8'h01;
              end
            end else begin
              sub_ff <= sub_ff + 12'd1;
            end
          end
        end
        WD_RSTPULSE: begin
          if (pulse_ff == ($clog2(RST_PULSE_CYCLES+1))'(RST_PULSE_CYCLES - 1)) begin
            wd_state_ff <= WD_IDLE;
            watchdog_timeout_config_ff <= `WDOG_RESET_VALUE;
          end else begin
            pulse_ff <= pulse_ff + ($clog2(RST_PULSE_CYCLES+1))'(1);
          end
        end
        default: wd_state_ff <= WD_IDLE;
      endcase
    end
  end

  // watchdog flag; set wins over clear
  always_ff @(posedge clk_sys or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      watchdog_expired_flag_ff <= 1'b0;
      wd_irq_ff <= 1'b0;
    end else begin
      if (wd_timeout) watchdog_expired_flag_ff <= 1'b1;
      else if (flags_end) watchdog_expired_flag_ff <= 1'b0;
      if (wd_timeout && !watchdog_timeout_config_ff[`WDOG_STEER_BIT]) wd_irq_ff <= 1'b1;
      else if (flags_end || wd_end) wd_irq_ff <= 1'b0;
    end
  end

  // 512 Hz square wave from the oscillator tick
  logic [11:0] ft_cnt_ff;
  logic ft_wave_ff;
  logic ft_allowed, wd_on_pin;
  assign wd_on_pin = !watchdog_timeout_config_ff[`WDOG_STEER_BIT] && watchdog_timeout_config_ff != 8'h00;
  assign ft_allowed = freq_test_bit && !alarm_irq_enable && !wd_on_pin;
  always_ff @(posedge clk_sys or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      ft_cnt_ff <= 12'h000;
      ft_wave_ff <= 1'b0;
    end else if (!ft_allowed) begin
      ft_cnt_ff <= 12'h000;
      ft_wave_ff <= 1'b0;
    end else if (osc_tick) begin
      if (ft_cnt_ff == `FREQ_TEST_HALF_TICKS - 12'd1) begin
        ft_cnt_ff <= 12'h000;
        ft_wave_ff <= !ft_wave_ff;
      end else begin
        ft_cnt_ff <= ft_cnt_ff + 12'd1;
      end
    end
  end

  // pins: open drain, low level driven when enable low
  logic nxt_irq_drive;
  // mask the watchdog term as it clears, so the pin does not dip once more after the access
  assign nxt_irq_drive = alarm_irq_ff || (wd_irq_ff && !flags_end && !wd_end) || ft_wave_ff;
  always_ff @(posedge clk_sys or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      irq_freqtest_out <= 1'b0;
      irq_freqtest_oe_n <= 1'b1;
      rst_out <= 1'b0;
      rst_oe_n <= 1'b1;
      freq_test_clear <= 1'b0;
    end else begin
      irq_freqtest_out <= 1'b0;
      irq_freqtest_oe_n <= !(nxt_irq_drive && !flags_acc_now);
      rst_out <= 1'b0;
      rst_oe_n <= wd_state_ff != WD_RSTPULSE;
      freq_test_clear <= wd_state_ff == WD_RSTPULSE && pulse_ff == ($clog2(RST_PULSE_CYCLES+1))'(RST_PULSE_CYCLES - 1);
    end
  end

  // read data
  logic [7:0] nxt_dq;
  always_comb begin
    case (addr)
      `ADDR_EVENT_FLAGS: begin
        nxt_dq = 8'h00;
        nxt_dq[`FLAG_WATCHDOG_BIT] = watchdog_expired_flag_ff;
        nxt_dq[`FLAG_ALARM_BIT] = alarm_match_flag_ff;
        nxt_dq[`FLAG_BATT_LOW_BIT] = battery_low_flag;
      end
      `ADDR_ALARM_SEC: nxt_dq = alarm_sec_ff;
      `ADDR_ALARM_MIN: nxt_dq = alarm_min_ff;
      `ADDR_ALARM_HOUR: nxt_dq = alarm_hour_ff;
      `ADDR_ALARM_DAY_MATCH: nxt_dq = alarm_day_match_ff;
      `ADDR_ALARM_IRQ_ENABLES: nxt_dq = alarm_interrupt_enables_ff;
      `ADDR_WATCHDOG_CFG: nxt_dq = watchdog_timeout_config_ff;
      default: nxt_dq = 8'h00;
    endcase
  end
  always_ff @(posedge clk_sys or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      dq_out <= 8'h00;
      dq_oe_n <= 1'b1;
    end else begin
      dq_out <= nxt_dq;
      dq_oe_n <= !(!ce_n && !oe_n && we_n);
    end
  end
endmodule

// file: rtc_alarm_cfg.svh
// register offsets, field positions, reset values and timing counts
`ifndef RTC_ALARM_CFG_SVH
`define RTC_ALARM_CFG_SVH
`define ADDR_EVENT_FLAGS 19'h7fff0
`define ADDR_ALARM_SEC 19'h7fff2
`define ADDR_ALARM_MIN 19'h7fff3
`define ADDR_ALARM_HOUR 19'h7fff4
`define ADDR_ALARM_DAY_MATCH 19'h7fff5
`define ADDR_ALARM_IRQ_ENABLES 19'h7fff6
`define ADDR_WATCHDOG_CFG 19'h7fff7
`define FLAG_WATCHDOG_BIT 7
`define FLAG_ALARM_BIT 6
`define FLAG_BATT_LOW_BIT 4
`define EN_ALARM_IRQ_BIT 7
`define EN_BACKUP_BIT 5
`define MASK_BIT 7
`define WDOG_STEER_BIT 7
`define WDOG_RESET_VALUE 8'h00
`define ENABLES_RESET_VALUE 8'h00
`define ALARM_RESET_VALUE 8'h00
// one sixteenth of a second in 32.768 kHz oscillator ticks
`define TICKS_SIXTEENTH 12'd2048
`define FREQ_TEST_HALF_TICKS 12'd32
// reset pulse 40 ms to 200 ms; aim at 100 ms
`define RST_PULSE_MS 100
`define CLK_HZ 10000000
`define RST_PULSE_CYCLES ((`CLK_HZ / 1000) * `RST_PULSE_MS)
`endif

// file: rtc_alarm_pkg.sv
// types shared by the alarm and watchdog unit
package rtc_alarm_pkg;
  typedef enum logic [2:0] {
    WD_IDLE = 3'b001,
    WD_COUNT = 3'b010,
    WD_RSTPULSE = 3'b100
  } wd_state_t;
  typedef enum logic [2:0] {
    RATE_EVERY_SEC = 3'h0,
    RATE_SEC = 3'h1,
    RATE_MIN_SEC = 3'h2,
    RATE_HMS = 3'h3,
    RATE_DHMS = 3'h4
  } alarm_rate_t;
endpackage

// file: alarm_match.sv
// alarm comparator: mask decode and time match
`timescale 1ns/10ps
`include "rtc_alarm_cfg.svh"
module alarm_match
  import rtc_alarm_pkg::*;
(
  input wire logic [7:0] alarm_sec,
  input wire logic [7:0] alarm_min,
  input wire logic [7:0] alarm_hour,
  input wire logic [7:0] alarm_day,
  input wire logic [6:0] now_sec,
  input wire logic [6:0] now_min,
  input wire logic [5:0] now_hour,
  input wire logic [5:0] now_day,
  output logic hit
);
  function automatic alarm_rate_t decode_rate(input logic [3:0] m);
    case (m)
      4'hf: decode_rate = RATE_EVERY_SEC;
      4'he: decode_rate = RATE_SEC;
      4'hc: decode_rate = RATE_MIN_SEC;
      4'h8: decode_rate = RATE_HMS;
      4'h0: decode_rate = RATE_DHMS;
      default: decode_rate = RATE_EVERY_SEC;
    endcase
  endfunction
  alarm_rate_t rate;
  logic s_eq, m_eq, h_eq, d_eq;
  always_comb begin
    rate = decode_rate({alarm_day[`MASK_BIT], alarm_hour[`MASK_BIT], alarm_min[`MASK_BIT], alarm_sec[`MASK_BIT]});
    s_eq = alarm_sec[6:0] == now_sec;
    m_eq = alarm_min[6:0] == now_min;
    h_eq = alarm_hour[5:0] == now_hour;
    d_eq = alarm_day[5:0] == now_day;
    case (rate)
      RATE_SEC: hit = s_eq;
      RATE_MIN_SEC: hit = s_eq && m_eq;
      RATE_HMS: hit = s_eq && m_eq && h_eq;
      RATE_DHMS: hit = s_eq && m_eq && h_eq && d_eq;
      default: hit = 1'b1;
    endcase
  end
endmodule

// file: rtc_alarm_and_watchdog_props.sv
// assertion checker for the alarm and watchdog unit
`timescale 1ns/10ps
`include "rtc_alarm_cfg.svh"
module rtc_alarm_and_watchdog_props #(
  parameter int unsigned RST_PULSE_CYCLES = 20
) (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic [18:0] addr,
  input wire logic [7:0] dq_out,
  input wire logic dq_oe_n,
  input wire logic ce_n,
  input wire logic oe_n,
  input wire logic we_n,
  input wire logic battery_low_flag,
  input wire logic freq_test_clear,
  input wire logic irq_freqtest_out,
  input wire logic irq_freqtest_oe_n,
  input wire logic rst_out,
  input wire logic rst_oe_n
);
  logic [31:0] low_cnt_ff;
  wire logic rd_now = !ce_n && !oe_n && we_n;
  // length of the current reset pulse in cycles
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      low_cnt_ff <= '0;
    end else begin
      low_cnt_ff <= rst_oe_n ? 32'h0 : low_cnt_ff + 32'h1;
    end
  end
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  a_dq_drive: assert property (rd_now |=> !dq_oe_n) else $error("read not driven");
  a_dq_idle: assert property (ce_n |=> dq_oe_n) else $error("data driven while deselected");
  a_unmapped_zero: assert property (rd_now && addr < 19'h7fff0 |=> dq_out == 8'h00)
    else $error("unmapped read not zero");
  a_flag_bits: assert property (rd_now && addr == `ADDR_EVENT_FLAGS |=>
    dq_out[5] == 1'b0 && dq_out[3:0] == 4'h0 && dq_out[4] == $past(battery_low_flag))
    else $error("flags byte layout wrong");
  a_pins_low: assert property (irq_freqtest_out == 1'b0 && rst_out == 1'b0) else $error("open drain drives high");
  a_rst_len: assert property ($rose(rst_oe_n) |-> low_cnt_ff == RST_PULSE_CYCLES)
    else $error("reset pulse length wrong");
  a_ftclr_end: assert property ($rose(rst_oe_n) |-> $past(freq_test_clear))
    else $error("test bit clear missing");
  a_ftclr_pulse: assert property (freq_test_clear |-> (!$past(rst_oe_n) || !$past(rst_oe_n, 2)) ##1 !freq_test_clear)
    else $error("stray test bit clear");
  a_irq_release: assert property ((!ce_n && addr == `ADDR_EVENT_FLAGS && (!oe_n || !we_n)) ##1 ce_n |->
    ##[0:1] irq_freqtest_oe_n) else $error("interrupt held after flags access");
endmodule
bind rtc_alarm_and_watchdog rtc_alarm_and_watchdog_props #(.RST_PULSE_CYCLES(RST_PULSE_CYCLES)) props_i (
  .clk_sys(clk_sys), .resetn(resetn), .addr(addr), .dq_out(dq_out), .dq_oe_n(dq_oe_n), .ce_n(ce_n),
  .oe_n(oe_n), .we_n(we_n), .battery_low_flag(battery_low_flag), .freq_test_clear(freq_test_clear),
  .irq_freqtest_out(irq_freqtest_out), .irq_freqtest_oe_n(irq_freqtest_oe_n), .rst_out(rst_out),
  .rst_oe_n(rst_oe_n));

// file: host_bus_model.sv
// host processor model on the byte-wide memory bus
`timescale 1ns/10ps
module host_bus_model (
  input wire logic clk_sys,
  input wire logic [7:0] dq_out,
  output logic [18:0] addr,
  output logic [7:0] dq_in,
  output logic ce_n,
  output logic oe_n,
  output logic we_n
);
  initial begin
    addr = 19'h0;
    dq_in = 8'h0;
    ce_n = 1'b1;
    oe_n = 1'b1;
    we_n = 1'b1;
  end
  task automatic acc(input logic [18:0] a, input logic [7:0] d, input logic wr, output logic [7:0] q);
    @(posedge clk_sys);
    addr <= a;
    dq_in <= d;
    ce_n <= 1'b0;
    oe_n <= wr;
    we_n <= !wr;
    // two sampled cycles cover a full read cycle time
    repeat (2) @(posedge clk_sys);
    q = dq_out;
    ce_n <= 1'b1;
    oe_n <= 1'b1;
    we_n <= 1'b1;
    // released lines show the inverse, never a stale copy
    addr <= ~a;
    dq_in <= ~d;
  endtask
endmodule

// file: rtc_alarm_and_watchdog_tb.sv
// self-checking bench for the alarm and watchdog unit
`timescale 1ns/10ps
`include "rtc_alarm_cfg.svh"
module rtc_alarm_and_watchdog_tb;
  localparam logic [18:0] flags_a = `ADDR_EVENT_FLAGS;
  localparam logic [18:0] en_a = `ADDR_ALARM_IRQ_ENABLES;
  localparam logic [18:0] wd_a = `ADDR_WATCHDOG_CFG;
  logic clk_sys, resetn, osc_tick, second_tick, on_battery, power_up, battery_low_flag, freq_test_bit;
  logic [6:0] now_sec, now_min;
  logic [5:0] now_hour, now_day;
  logic [18:0] addr;
  logic [7:0] dq_in, dq_out, q;
  logic dq_oe_n, ce_n, oe_n, we_n, freq_test_clear, irq_freqtest_out, irq_freqtest_oe_n, rst_out, rst_oe_n;
  int n_errors, check_count, n;
  rtc_alarm_and_watchdog #(.RST_PULSE_CYCLES(20)) rtc_alarm_and_watchdog_i (
    .clk_sys(clk_sys), .resetn(resetn), .addr(addr), .dq_in(dq_in), .dq_out(dq_out), .dq_oe_n(dq_oe_n),
    .ce_n(ce_n), .oe_n(oe_n), .we_n(we_n), .osc_tick(osc_tick), .second_tick(second_tick),
    .now_sec(now_sec), .now_min(now_min), .now_hour(now_hour), .now_day(now_day), .on_battery(on_battery),
    .power_up(power_up), .battery_low_flag(battery_low_flag), .freq_test_bit(freq_test_bit),
    .freq_test_clear(freq_test_clear), .irq_freqtest_out(irq_freqtest_out),
    .irq_freqtest_oe_n(irq_freqtest_oe_n), .rst_out(rst_out), .rst_oe_n(rst_oe_n));
  host_bus_model host_bus_model_i (.clk_sys(clk_sys), .dq_out(dq_out), .addr(addr), .dq_in(dq_in),
    .ce_n(ce_n), .oe_n(oe_n), .we_n(we_n));
  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    osc_tick <= ~osc_tick;
    if (freq_test_clear) begin
      freq_test_bit <= 1'b0;
    end
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [18:0] a, input logic [7:0] d);
    host_bus_model_i.acc(a, d, 1'b1, q);
  endtask
  task automatic rd(input logic [18:0] a, input logic [7:0] exp);
    host_bus_model_i.acc(a, 8'h00, 1'b0, q);
    chk(q, exp);
  endtask
  task automatic tick(input logic [6:0] s, input logic [6:0] m, input logic [5:0] h, input logic [5:0] d);
    @(posedge clk_sys);
    now_sec <= s;
    now_min <= m;
    now_hour <= h;
    now_day <= d;
    second_tick <= 1'b1;
    @(posedge clk_sys);
    second_tick <= 1'b0;
    repeat (3) @(posedge clk_sys);
  endtask
  task automatic judge(input logic fl, input logic pin);
    chk({7'h0, irq_freqtest_oe_n}, {7'h0, !pin});
    rd(flags_a, {1'b0, fl, 6'h10});
    repeat (2) @(posedge clk_sys);
    chk({7'h0, irq_freqtest_oe_n}, 8'h01);
    rd(flags_a, 8'h10);
  endtask
  // bounded wait for either pin to go low
  task automatic wd_wait(input int max);
    for (n = 0; n < max; n++) begin
      @(posedge clk_sys);
      if (!irq_freqtest_oe_n || !rst_oe_n) begin
        break;
      end
    end
  endtask
  task automatic t_regs;
    rd(wd_a, 8'h00);
    rd(en_a, 8'h00);
    wr(flags_a, 8'hff);
    rd(flags_a, 8'h10);
    wr(en_a, 8'h5a);
    rd(en_a, 8'h5a);
    rd(19'h00010, 8'h00);
    $display("test regs done");
  endtask
  task automatic t_alarm;
    logic [3:0] mk[6] = '{4'hf, 4'he, 4'hc, 4'h8, 4'h0, 4'h5};
    int nf[6] = '{0, 1, 2, 3, 4, 0};
    logic [3:0] x;
    wr(en_a, 8'h80);
    for (int i = 0; i < 6; i++) begin
      wr(`ADDR_ALARM_SEC, {mk[i][0], 7'h12});
      wr(`ADDR_ALARM_MIN, {mk[i][1], 7'h34});
      wr(`ADDR_ALARM_HOUR, {mk[i][2], 7'h05});
      wr(`ADDR_ALARM_DAY_MATCH, {mk[i][3], 7'h06});
      // spoil only the highest compared field, or the seconds when no field is compared
      x = (nf[i] == 0) ? 4'h1 : 4'h1 << (nf[i] - 1);
      tick(7'h12 ^ {6'h0, x[0]}, 7'h34 ^ {6'h0, x[1]}, 6'h05 ^ {5'h0, x[2]}, 6'h06 ^ {5'h0, x[3]});
      judge(nf[i] == 0, nf[i] == 0);
      tick(7'h12, 7'h34, 6'h05, 6'h06);
      judge(1'b1, 1'b1);
    end
    $display("test alarm done");
  endtask
  task automatic t_backup;
    on_battery <= 1'b1;
    wr(en_a, 8'h80);
    tick(7'h12, 7'h34, 6'h05, 6'h06);
    judge(1'b1, 1'b0);
    wr(en_a, 8'ha0);
    tick(7'h12, 7'h34, 6'h05, 6'h06);
    judge(1'b1, 1'b1);
    on_battery <= 1'b0;
    $display("test backup done");
  endtask
  task automatic t_power;
    wr(en_a, 8'ha5);
    wr(wd_a, 8'h7c);
    power_up <= 1'b1;
    tick(7'h12, 7'h34, 6'h05, 6'h06);
    power_up <= 1'b0;
    judge(1'b1, 1'b0);
    rd(en_a, 8'h05);
    rd(wd_a, 8'h00);
    $display("test power done");
  endtask
  task automatic t_wdog;
    wr(wd_a, 8'h08);
    freq_test_bit <= 1'b1;
    wd_wait(8400);
    chk({7'h0, n >= 8092 && n <= 8292}, 8'h01);
    chk({7'h0, irq_freqtest_oe_n}, 8'h00);
    freq_test_bit <= 1'b0;
    rd(flags_a, 8'h90);
    wr(wd_a, 8'h05);
    wd_wait(16600);
    chk({7'h0, n >= 16284 && n <= 16484}, 8'h01);
    rd(wd_a, 8'h05);
    repeat (2) @(posedge clk_sys);
    chk({7'h0, irq_freqtest_oe_n}, 8'h01);
    rd(flags_a, 8'h90);
    wr(wd_a, 8'h04);
    repeat (3000) @(posedge clk_sys);
    rd(wd_a, 8'h04);
    wd_wait(4400);
    chk({7'h0, n >= 3996 && n <= 4196}, 8'h01);
    rd(flags_a, 8'h90);
    wr(wd_a, 8'h04);
    wr(wd_a, 8'h00);
    wd_wait(9000);
    chk({7'h0, n == 9000}, 8'h01);
    $display("test watchdog done");
  endtask
  task automatic t_steer;
    // alarm enable set keeps the square wave off the pin
    wr(en_a, 8'h80);
    freq_test_bit <= 1'b1;
    wr(wd_a, 8'h84);
    wd_wait(4400);
    chk({6'h0, irq_freqtest_oe_n, rst_oe_n}, 8'h02);
    repeat (30) @(posedge clk_sys);
    chk({6'h0, rst_oe_n, freq_test_bit}, 8'h02);
    rd(wd_a, 8'h00);
    $display("test steering done");
  endtask
  task automatic t_freq;
    int lo;
    // wave only with alarm enable clear and the watchdog off the pin
    wr(en_a, 8'h00);
    freq_test_bit <= 1'b1;
    wd_wait(200);
    lo = 1;
    for (n = 0; n < 200; n++) begin
      @(posedge clk_sys);
      if (irq_freqtest_oe_n) begin
        break;
      end
      lo++;
    end
    // half period is 32 oscillator ticks, one tick every two clocks
    chk(lo[7:0], 8'h40);
    freq_test_bit <= 1'b0;
    repeat (3) @(posedge clk_sys);
    chk({7'h0, irq_freqtest_oe_n}, 8'h01);
    $display("test freq done");
  endtask
  task automatic test_done;
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  initial begin
    resetn = 1'b0;
    osc_tick = 1'b0;
    second_tick = 1'b0;
    now_sec = 7'h0;
    now_min = 7'h0;
    now_hour = 6'h0;
    now_day = 6'h0;
    on_battery = 1'b0;
    power_up = 1'b0;
    battery_low_flag = 1'b1;
    freq_test_bit = 1'b0;
    n_errors = 0;
    check_count = 0;
    repeat (4) @(posedge clk_sys);
    resetn <= 1'b1;
    repeat (3) @(posedge clk_sys);
    t_regs;
    t_alarm;
    t_backup;
    t_power;
    t_wdog;
    t_steer;
    t_freq;
    test_done;
  end
endmodule
